// file: core/ccs_clock_switch.sv
// Overview of operation
// [RULE1] software starts internal oscillator before leaving subclock
// [RULE2] software enables and stabilises crystal before selecting
// [RULE3] software enables external clock input before selecting
// [RULE4] fast oscillator only swaps with internal clock
// [RULE5] fast oscillator left by clearing its select
// [RULE6] control register selects divider, main, cpu source
// [RULE7] old clock keeps running until switchover completes
// [RULE8] bit 7 reports active cpu source
// [RULE9] bit 5 reports active main source
// [RULE10] peripheral clock follows cpu clock
// [RULE11] divider change ends within bounded old clocks
// [RULE12] main source change ends within bounded clocks
// [RULE13] cpu source change ends within bounded clocks
// [RULE14] limits counted in pre-switch cpu clocks
// [RULE15] tolerate rounded-up cycle counts
// [RULE16] stop internal oscillator only when unused
// [RULE17] stop high-speed clock only when unused
// [RULE18] stop subclock only when cpu on main
// [RULE19] stop fast oscillator only after deselecting
// [RULE20] crystal versus external choice fixed until reset
// [RULE21] clock handover happens without shortened phases
//
// Implementation choices: the AXI4-Lite interface to the registers and the register offsets.
`default_nettype none
module ccs_clock_switch
    import ccs_pkg::*;
#(
    parameter int ADDR_W = 4
)(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic int_hs_tick,
    input wire logic hs_sys_tick,
    input wire logic sub_tick,
    input wire logic fast_tick,
    output logic cpu_clk_en,
    output logic periph_clk_en,
    output logic int_hs_osc_run,
    output logic main_crystal_run,
    output logic ext_clk_input_en,
    output logic sub_crystal_run,
    output logic fast_osc_run
);

    if (ADDR_W < 4 || ADDR_W > 32)
    begin : g_bad_addr_w
        $error("ADDR_W must lie between 4 and 32");
    end

    // bus side state
    logic aw_hold_q, aw_hold_d;
    logic w_hold_q, w_hold_d;
    logic [ADDR_W-1:0] waddr_q, waddr_d;
    logic [7:0] wdata_q, wdata_d;
    logic wstrb0_q, wstrb0_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic rvalid_q, rvalid_d;
    logic [7:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;
    logic do_wr;
    logic wr_ckc, wr_osc;

    // software registers
    logic [CCS_DIV_W-1:0] div_q, div_d;
    logic mcm_q, mcm_d;
    logic css_q, css_d;
    logic hs_osc_stop_q, hs_osc_stop_d;
    logic hs_sys_stop_q, hs_sys_stop_d;
    logic sub_stop_q, sub_stop_d;
    logic hs_sys_en_q, hs_sys_en_d;
    logic ext_sel_q, ext_sel_d;
    logic fast_sel_q, fast_sel_d;
    logic fast_on_q, fast_on_d;
    logic hs_lock_q, hs_lock_d;

    // active clock state
    ccs_sw_state_type sw_q, sw_d;
    logic [CCS_DIV_W-1:0] div_act_q, div_act_d, div_tgt_q, div_tgt_d;
    logic mcs_q, mcs_d, mcs_tgt_q, mcs_tgt_d;
    logic cls_q, cls_d, cls_tgt_q, cls_tgt_d;
    logic fast_act_q, fast_act_d, fast_tgt_q, fast_tgt_d;
    logic [CCS_DIVCNT_W-1:0] div_cnt_q, div_cnt_d;
    logic [CCS_DIVCNT_W-1:0] div_mask;
    logic main_src_tick, main_tick, cpu_tick_act, tgt_tick;
    logic cfg_diff;
    logic [7:0] ckc_view, osc_view;

    assign do_wr = aw_hold_q && w_hold_q && !bvalid_q;
    assign wr_ckc = do_wr && wstrb0_q && (waddr_q[3:0] == CCS_ADDR_CLK_CTRL);
    assign wr_osc = do_wr && wstrb0_q && (waddr_q[3:0] == CCS_ADDR_OSC_CTRL);

    assign s_axi_awready = !aw_hold_q && !bvalid_q;
    assign s_axi_wready = !w_hold_q && !bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = {24'h000000, rdata_q};
    assign s_axi_rresp = rresp_q;

    // [RULE8] [RULE9] status shows active sources
    assign ckc_view = {cls_q, css_q, mcs_q, mcm_q, 1'b0, div_q};
    assign osc_view = {sw_q != CCS_SW_IDLE, fast_on_q, fast_sel_q, ext_sel_q,
                       hs_sys_en_q, sub_stop_q, hs_sys_stop_q, hs_osc_stop_q};

    always_comb
    begin
        aw_hold_d = aw_hold_q;
        w_hold_d = w_hold_q;
        waddr_d = waddr_q;
        wdata_d = wdata_q;
        wstrb0_d = wstrb0_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_hold_d = 1'b1;
            waddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_hold_d = 1'b1;
            wdata_d = s_axi_wdata[7:0];
            wstrb0_d = s_axi_wstrb[0];
        end
        if (do_wr)
        begin
            aw_hold_d = 1'b0;
            w_hold_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = (waddr_q[3:0] == CCS_ADDR_CLK_CTRL || waddr_q[3:0] == CCS_ADDR_OSC_CTRL)
                      ? CCS_RESP_OKAY : CCS_RESP_SLVERR;
        end
        else if (bvalid_q && s_axi_bready)
        begin
            bvalid_d = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_d = 1'b1;
            rresp_d = CCS_RESP_OKAY;
            if (s_axi_araddr[3:0] == CCS_ADDR_CLK_CTRL)
            begin
                rdata_d = ckc_view;
            end
            else if (s_axi_araddr[3:0] == CCS_ADDR_OSC_CTRL)
            begin
                rdata_d = osc_view;
            end
            else
            begin
                rdata_d = 8'h00;
                rresp_d = CCS_RESP_SLVERR;
            end
        end
        else if (rvalid_q && s_axi_rready)
        begin
            rvalid_d = 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            waddr_q <= '0;
            wdata_q <= 8'h00;
            wstrb0_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= CCS_RESP_OKAY;
            rvalid_q <= 1'b0;
            rdata_q <= 8'h00;
            rresp_q <= CCS_RESP_OKAY;
        end
        else
        begin
            aw_hold_q <= aw_hold_d;
            w_hold_q <= w_hold_d;
            waddr_q <= waddr_d;
            wdata_q <= wdata_d;
            wstrb0_q <= wstrb0_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    always_comb
    begin
        div_d = div_q;
        mcm_d = mcm_q;
        css_d = css_q;
        hs_osc_stop_d = hs_osc_stop_q;
        hs_sys_stop_d = hs_sys_stop_q;
        sub_stop_d = sub_stop_q;
        hs_sys_en_d = hs_sys_en_q;
        ext_sel_d = ext_sel_q;
        fast_sel_d = fast_sel_q;
        fast_on_d = fast_on_q;
        hs_lock_d = hs_lock_q;
        // [RULE6] selection fields written
        if (wr_ckc)
        begin
            if (wdata_q[CCS_DIV_MSB:CCS_DIV_LSB] <= CCS_DIV_MAX)
            begin
                div_d = wdata_q[CCS_DIV_MSB:CCS_DIV_LSB];
            end
            // [RULE4] sources frozen on fast oscillator
            if (!fast_sel_q)
            begin
                mcm_d = wdata_q[CCS_MSRC_SEL_BIT];
                css_d = wdata_q[CCS_CPU_SEL_BIT];
            end
        end
        if (wr_osc)
        begin
            hs_osc_stop_d = wdata_q[CCS_HS_OSC_STOP_BIT];
            hs_sys_stop_d = wdata_q[CCS_HS_SYS_STOP_BIT];
            sub_stop_d = wdata_q[CCS_SUB_STOP_BIT];
            fast_on_d = wdata_q[CCS_FAST_ON_BIT];
            // [RULE20] crystal or external fixed once chosen
            if (!hs_lock_q)
            begin
                hs_sys_en_d = wdata_q[CCS_HS_SYS_EN_BIT];
                ext_sel_d = wdata_q[CCS_EXT_SEL_BIT];
                hs_lock_d = wdata_q[CCS_HS_SYS_EN_BIT];
            end
            // [RULE4] fast select only from internal clock
            if (!wdata_q[CCS_FAST_SEL_BIT])
            begin
                fast_sel_d = 1'b0;
            end
            else if (!mcm_q && !css_q && !mcs_q && !cls_q)
            begin
                fast_sel_d = 1'b1;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            div_q <= CCS_RST_DIV;
            mcm_q <= 1'b0;
            css_q <= 1'b0;
            hs_osc_stop_q <= CCS_RST_HS_OSC_STOP;
            hs_sys_stop_q <= CCS_RST_HS_SYS_STOP;
            sub_stop_q <= CCS_RST_SUB_STOP;
            hs_sys_en_q <= 1'b0;
            ext_sel_q <= 1'b0;
            fast_sel_q <= 1'b0;
            fast_on_q <= 1'b0;
            hs_lock_q <= 1'b0;
        end
        else
        begin
            div_q <= div_d;
            mcm_q <= mcm_d;
            css_q <= css_d;
            hs_osc_stop_q <= hs_osc_stop_d;
            hs_sys_stop_q <= hs_sys_stop_d;
            sub_stop_q <= sub_stop_d;
            hs_sys_en_q <= hs_sys_en_d;
            ext_sel_q <= ext_sel_d;
            fast_sel_q <= fast_sel_d;
            fast_on_q <= fast_on_d;
            hs_lock_q <= hs_lock_d;
        end
    end

    assign div_mask = CCS_DIVCNT_W'((5'h01 << div_act_q) - 5'h01);
    assign main_src_tick = fast_act_q ? fast_tick : (mcs_q ? hs_sys_tick : int_hs_tick);
    assign main_tick = main_src_tick && (div_cnt_q == div_mask);
    assign cpu_tick_act = cls_q ? sub_tick : main_tick;
    assign tgt_tick = cls_tgt_q ? sub_tick
                    : (fast_tgt_q ? fast_tick : (mcs_tgt_q ? hs_sys_tick : int_hs_tick));
    assign cfg_diff = (div_q != div_act_q) || (mcm_q != mcs_q) || (css_q != cls_q)
                   || (fast_sel_q != fast_act_q);

    // [RULE21] no cpu edge while handing over
    assign cpu_clk_en = (sw_q != CCS_SW_NEW) && cpu_tick_act;
    // [RULE10] peripheral clock follows cpu
    assign periph_clk_en = cpu_clk_en;

    assign int_hs_osc_run = !hs_osc_stop_q;
    assign main_crystal_run = hs_sys_en_q && !ext_sel_q && !hs_sys_stop_q;
    assign ext_clk_input_en = hs_sys_en_q && ext_sel_q && !hs_sys_stop_q;
    assign sub_crystal_run = !sub_stop_q;
    assign fast_osc_run = fast_on_q;

    always_comb
    begin
        sw_d = sw_q;
        div_act_d = div_act_q;
        mcs_d = mcs_q;
        cls_d = cls_q;
        fast_act_d = fast_act_q;
        div_tgt_d = div_tgt_q;
        mcs_tgt_d = mcs_tgt_q;
        cls_tgt_d = cls_tgt_q;
        fast_tgt_d = fast_tgt_q;
        div_cnt_d = div_cnt_q;
        if (main_src_tick)
        begin
            div_cnt_d = (div_cnt_q == div_mask) ? '0 : CCS_DIVCNT_W'(div_cnt_q + 1'b1);
        end
        case (sw_q)
            CCS_SW_IDLE:
            begin
                // [RULE7] old clock runs until handover
                if (cfg_diff)
                begin
                    sw_d = CCS_SW_OLD;
                    div_tgt_d = div_q;
                    mcs_tgt_d = mcm_q;
                    cls_tgt_d = css_q;
                    fast_tgt_d = fast_sel_q;
                end
            end
            CCS_SW_OLD:
            begin
                // [RULE14] finish the current old cpu clock
                if (cpu_tick_act)
                begin
                    sw_d = CCS_SW_NEW;
                end
            end
            CCS_SW_NEW:
            begin
                // [RULE11] [RULE12] [RULE13] commit on new edge
                if (tgt_tick)
                begin
                    sw_d = CCS_SW_IDLE;
                    div_act_d = div_tgt_q;
                    mcs_d = mcs_tgt_q;
                    cls_d = cls_tgt_q;
                    fast_act_d = fast_tgt_q;
                    div_cnt_d = '0;
                end
            end
            default:
            begin
                sw_d = CCS_SW_IDLE;
            end
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sw_q <= CCS_SW_IDLE;
            div_act_q <= CCS_RST_DIV;
            mcs_q <= 1'b0;
            cls_q <= 1'b0;
            fast_act_q <= 1'b0;
            div_tgt_q <= CCS_RST_DIV;
            mcs_tgt_q <= 1'b0;
            cls_tgt_q <= 1'b0;
            fast_tgt_q <= 1'b0;
            div_cnt_q <= '0;
        end
        else
        begin
            sw_q <= sw_d;
            div_act_q <= div_act_d;
            mcs_q <= mcs_d;
            cls_q <= cls_d;
            fast_act_q <= fast_act_d;
            div_tgt_q <= div_tgt_d;
            mcs_tgt_q <= mcs_tgt_d;
            cls_tgt_q <= cls_tgt_d;
            fast_tgt_q <= fast_tgt_d;
            div_cnt_q <= div_cnt_d;
        end
    end

endmodule // ccs_clock_switch
`default_nettype wire

// file: core/ccs_pkg.sv
`default_nettype none
package ccs_pkg;
    // register byte offsets
    localparam logic [3:0] CCS_ADDR_CLK_CTRL = 4'h0;
    localparam logic [3:0] CCS_ADDR_OSC_CTRL = 4'h4;
    // system_clock_control fields
    localparam int CCS_DIV_LSB = 0;
    localparam int CCS_DIV_MSB = 2;
    localparam int CCS_MSRC_SEL_BIT = 4;
    localparam int CCS_MSRC_STAT_BIT = 5;
    localparam int CCS_CPU_SEL_BIT = 6;
    localparam int CCS_CPU_STAT_BIT = 7;
    localparam int CCS_DIV_W = 3;
    localparam int CCS_DIVCNT_W = 4;
    localparam logic [CCS_DIV_W-1:0] CCS_DIV_MAX = 3'h4;
    // oscillator control fields
    localparam int CCS_HS_OSC_STOP_BIT = 0;
    localparam int CCS_HS_SYS_STOP_BIT = 1;
    localparam int CCS_SUB_STOP_BIT = 2;
    localparam int CCS_HS_SYS_EN_BIT = 3;
    localparam int CCS_EXT_SEL_BIT = 4;
    localparam int CCS_FAST_SEL_BIT = 5;
    localparam int CCS_FAST_ON_BIT = 6;
    localparam int CCS_BUSY_BIT = 7;
    // reset values
    localparam logic [CCS_DIV_W-1:0] CCS_RST_DIV = 3'h0;
    localparam logic CCS_RST_HS_OSC_STOP = 1'b0;
    localparam logic CCS_RST_HS_SYS_STOP = 1'b1;
    localparam logic CCS_RST_SUB_STOP = 1'b1;
    // bus responses
    localparam logic [1:0] CCS_RESP_OKAY = 2'h0;
    localparam logic [1:0] CCS_RESP_SLVERR = 2'h2;
    // bus clock
    localparam int CCS_ACLK_HZ = 20000000;

    typedef enum logic [1:0] {
        CCS_SW_IDLE = 2'b00,
        CCS_SW_OLD = 2'b01,
        CCS_SW_NEW = 2'b10
    } ccs_sw_state_type;
endpackage : ccs_pkg
`default_nettype wire

// file: verification/ccs_clock_switch_checker.sv
`default_nettype none
module ccs_clock_switch_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic int_hs_tick,
    input wire logic hs_sys_tick,
    input wire logic sub_tick,
    input wire logic fast_tick,
    input wire logic cpu_clk_en,
    input wire logic periph_clk_en,
    input wire logic int_hs_osc_run,
    input wire logic main_crystal_run,
    input wire logic ext_clk_input_en,
    input wire logic sub_crystal_run,
    input wire logic fast_osc_run
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int MAX_GAP = 1000;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence s_pulse;
        cpu_clk_en;
    endsequence
    sequence s_both_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    a_periph_follow: assert property (periph_clk_en == cpu_clk_en)
        else $error("peripheral enable differs from cpu enable");
    a_pulse_on_tick: assert property (cpu_clk_en |->
        (int_hs_tick || hs_sys_tick || sub_tick || fast_tick))
        else $error("cpu enable without a source tick");
    a_hs_exclusive: assert property (!(main_crystal_run && ext_clk_input_en))
        else $error("crystal and external input both on");
    a_clk_gap_bound: assert property (s_pulse |=> ##[0:MAX_GAP] s_pulse)
        else $error("cpu enable stalled too long");
    a_reset_source: assert property ($rose(aresetn) |-> cpu_clk_en == int_hs_tick)
        else $error("cpu not on internal clock after reset");
    a_reset_osc: assert property ($rose(aresetn) |-> int_hs_osc_run &&
        !sub_crystal_run && !main_crystal_run && !fast_osc_run)
        else $error("oscillator enables wrong after reset");
    a_write_answer: assert property (s_both_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid && s_axi_rdata[31:8] == 24'h0)
        else $error("read answer wrong");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
endmodule // ccs_clock_switch_checker
bind ccs_clock_switch ccs_clock_switch_checker u_chk (.*);
`default_nettype wire

// file: verification/cpu_clock_switch_control_tb.sv
`default_nettype none
module cpu_clock_switch_control_tb import ccs_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int P_INT = 3;
    localparam int P_HS = 5;
    localparam int P_SUB = 11;
    localparam int P_FAST = 2;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [3:0] s_axi_awaddr = 4'h0;
    logic [3:0] s_axi_araddr = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic int_hs_tick = 1'b0, hs_sys_tick = 1'b0, sub_tick = 1'b0, fast_tick = 1'b0;
    logic cpu_clk_en, periph_clk_en, int_hs_osc_run, main_crystal_run;
    logic ext_clk_input_en, sub_crystal_run, fast_osc_run;
    int n_fail = 0;
    int checked = 0;
    int cyc = 0;
    int tc [4] = '{0, 0, 0, 0};
    logic [7:0] mclk = 8'h00;
    logic [7:0] mosc = 8'h06;
    logic lock = 1'b0;

    ccs_clock_switch uut (.*);

    initial
    begin
        forever #25 aclk = ~aclk;
    end

    // free-running source ticks
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        tc[0] <= (tc[0] == P_INT - 1) ? 0 : tc[0] + 1;
        tc[1] <= (tc[1] == P_HS - 1) ? 0 : tc[1] + 1;
        tc[2] <= (tc[2] == P_SUB - 1) ? 0 : tc[2] + 1;
        tc[3] <= (tc[3] == P_FAST - 1) ? 0 : tc[3] + 1;
        int_hs_tick <= (tc[0] == 0);
        hs_sys_tick <= (tc[1] == 0);
        sub_tick <= (tc[2] == 0);
        fast_tick <= (tc[3] == 0);
    end

    task automatic stop_test();
        $display("checked %0d, n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wait_hi(ref logic s, output int n);
        n = 0;
        do
        begin
            @(posedge aclk);
            n++;
        end
        while (s !== 1'b1 && n < 300);
        if (s !== 1'b1)
        begin
            n_fail++;
            $display("timeout at %0t", $time);
            stop_test();
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
        int n;
        logic av;
        logic wv;
        av = 1'b1;
        wv = 1'b1;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while ((av || wv) && n < 300)
        begin
            @(posedge aclk);
            n++;
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
            av = av && !s_axi_awready;
            wv = wv && !s_axi_wready;
        end
        if (av || wv)
        begin
            n_fail++;
            $display("timeout at %0t", $time);
            stop_test();
        end
        // late ready leaves the response waiting
        repeat (2) @(posedge aclk);
        s_axi_bready <= 1'b1;
        wait_hi(s_axi_bvalid, n);
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, er);
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        wait_hi(s_axi_arready, n);
        s_axi_arvalid <= 1'b0;
        @(posedge aclk);
        s_axi_rready <= 1'b1;
        wait_hi(s_axi_rvalid, n);
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        chk(s_axi_rresp, er);
    endtask

    function automatic logic [31:0] clk_exp();
        return {24'h0, mclk[6], mclk[6], mclk[4], mclk[4], 1'b0, mclk[2:0]};
    endfunction

    function automatic int per_exp();
        if (mclk[6])
            return P_SUB;
        return (mosc[5] ? P_FAST : mclk[4] ? P_HS : P_INT) << mclk[2:0];
    endfunction

    // model update, write, wait for switch, then compare everything
    task automatic w(input logic [3:0] a, input logic [7:0] d);
        logic [31:0] v;
        int t0;
        int bound;
        int n;
        bound = per_exp() + 12;
        if (a == CCS_ADDR_CLK_CTRL)
        begin
            if (d[2:0] <= CCS_DIV_MAX)
                mclk[2:0] = d[2:0];
            if (!mosc[5])
                {mclk[6], mclk[4]} = {d[6], d[4]};
        end
        else if (a == CCS_ADDR_OSC_CTRL)
        begin
            mosc[2:0] = d[2:0];
            mosc[6] = d[6];
            if (!lock)
                mosc[4:3] = d[4:3];
            lock = mosc[3];
            mosc[5] = d[5] && !mclk[4] && !mclk[6];
        end
        bound = bound + per_exp();
        t0 = cyc;
        wr(a, d, (a == CCS_ADDR_CLK_CTRL || a == CCS_ADDR_OSC_CTRL) ? CCS_RESP_OKAY :
            CCS_RESP_SLVERR);
        do
            rd(CCS_ADDR_OSC_CTRL, v, CCS_RESP_OKAY);
        while (v[CCS_BUSY_BIT] && cyc - t0 < bound);
        chk(v, {24'h0, mosc});
        rd(CCS_ADDR_CLK_CTRL, v, CCS_RESP_OKAY);
        chk(v, clk_exp());
        chk({int_hs_osc_run, main_crystal_run, ext_clk_input_en, sub_crystal_run, fast_osc_run},
            {!mosc[0], mosc[3] & !mosc[4] & !mosc[1], mosc[3] & mosc[4] & !mosc[1],
            !mosc[2], mosc[6]});
        wait_hi(cpu_clk_en, n);
        wait_hi(cpu_clk_en, n);
        chk(n, per_exp());
    endtask

    initial
    begin
        logic [31:0] v;
        void'($urandom(69308));
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rd(CCS_ADDR_CLK_CTRL, v, CCS_RESP_OKAY);
        chk(v, clk_exp());
        rd(4'h8, v, CCS_RESP_SLVERR);
        chk(v, 32'h0);
        w(4'hC, 8'hFF);
        repeat (6) w(CCS_ADDR_CLK_CTRL, 8'($urandom) & 8'hAF);
        w(CCS_ADDR_CLK_CTRL, 8'h05);
        w(CCS_ADDR_CLK_CTRL, 8'h00);
        w(CCS_ADDR_OSC_CTRL, 8'h08);
        w(CCS_ADDR_OSC_CTRL, 8'h18);
        w(CCS_ADDR_CLK_CTRL, 8'h10);
        w(CCS_ADDR_OSC_CTRL, 8'h68);
        w(CCS_ADDR_CLK_CTRL, 8'h50);
        w(CCS_ADDR_CLK_CTRL, 8'h10);
        w(CCS_ADDR_CLK_CTRL, 8'h00);
        w(CCS_ADDR_OSC_CTRL, 8'h68);
        w(CCS_ADDR_CLK_CTRL, 8'h53);
        w(CCS_ADDR_OSC_CTRL, 8'h48);
        w(CCS_ADDR_OSC_CTRL, 8'h08);
        w(CCS_ADDR_CLK_CTRL, 8'h40);
        w(CCS_ADDR_OSC_CTRL, 8'h09);
        w(CCS_ADDR_OSC_CTRL, 8'h08);
        w(CCS_ADDR_CLK_CTRL, 8'h00);
        w(CCS_ADDR_OSC_CTRL, 8'h0E);
        // second reset frees the crystal or external choice
        @(posedge aclk);
        aresetn <= 1'b0;
        mclk = 8'h00;
        mosc = 8'h06;
        lock = 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd(CCS_ADDR_OSC_CTRL, v, CCS_RESP_OKAY);
        chk(v, {24'h0, mosc});
        w(CCS_ADDR_OSC_CTRL, 8'h18);
        w(CCS_ADDR_CLK_CTRL, 8'h40);
        w(CCS_ADDR_CLK_CTRL, 8'h50);
        w(CCS_ADDR_CLK_CTRL, 8'h10);
        w(CCS_ADDR_OSC_CTRL, 8'h08);
        stop_test();
    end
endmodule // cpu_clock_switch_control_tb
`default_nettype wire
